// [design/sep_consts.svh]
// Constants of the two-wire serial memory slave.
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
`define SEP_ADDR_W        11
`define SEP_DEPTH         2048
`define SEP_PAGE_BYTES    16
`define SEP_OFS_W         4
`define SEP_PAGE_W        7
`define SEP_DEV_CODE      4'ha
`define SEP_BITS_PER_BYTE 4'h8
`define SEP_T_WR_MS       5
`define SEP_CLK_MHZ       200
`define SEP_FILT_LEN      3
`define SEP_PIN_IDLE      3'h6
`endif

// [design/sep_pkg.sv]
// Types shared by the two-wire serial memory slave.
`include "sep_consts.svh"
package sep_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX   = 5'h02,
    S_ACK  = 5'h04,
    S_TX   = 5'h08,
    S_MACK = 5'h10
  } sep_state_t;
  typedef enum logic [2:0] {
    K_DEV  = 3'h1,
    K_ADDR = 3'h2,
    K_DATA = 3'h4
  } sep_kind_t;
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
  } sep_pins_t;
  typedef struct packed {
    logic                                 en;
    logic [`SEP_PAGE_W-1:0]               page;
    logic [`SEP_PAGE_BYTES-1:0]           mask;
    logic [`SEP_PAGE_BYTES-1:0][7:0]      data;
  } sep_page_wr_t;
endpackage

// [design/sep_filt.sv]
// Two-flop synchroniser and stability filter for the bus pins.
`timescale 1ns/10ps
`include "sep_consts.svh"
module sep_filt #(
  parameter int             W       = 3,
  parameter int             LEN     = `SEP_FILT_LEN,
  parameter logic [W-1:0]   RST_VAL = `SEP_PIN_IDLE
) (
  input  wire logic [W-1:0] din,  // Asynchronous pin levels.
  input  wire logic         clk,  // Sampling clock.
  input  wire logic         rst,  // Synchronous reset, high.
  output logic      [W-1:0] dout  // Filtered levels.
);
  localparam int CW = $clog2(LEN + 1);
  logic [W-1:0]  meta_r;
  logic [W-1:0]  sync_r;
  logic [CW-1:0] cnt_r [W];

  always_ff @(posedge clk) begin
    meta_r <= din;
    sync_r <= meta_r;
  end

  // A level passes only after LEN equal samples, so shorter pulses vanish.
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= RST_VAL;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < W; i++) begin
        if (sync_r[i] == dout[i]) begin
          cnt_r[i] <= '0;
        end else if (cnt_r[i] == CW'(LEN - 1)) begin
          dout[i]  <= sync_r[i];
          cnt_r[i] <= '0;
        end else begin
          cnt_r[i] <= cnt_r[i] + 1'b1;
        end
      end
    end
  end
endmodule // sep_filt

// [design/sep_array.sv]
// Storage array written one page at a time under a byte mask.
`timescale 1ns/10ps
`include "sep_consts.svh"
module sep_array #(
  parameter int DEPTH = `SEP_DEPTH,
  parameter int AW    = `SEP_ADDR_W
) (
  input  wire logic                  clk,     // Link clock.
  input  wire sep_pkg::sep_page_wr_t wr,      // Page commit.
  input  wire logic [AW-1:0]         rd_addr, // Read address.
  output logic      [7:0]            rd_data  // Read byte.
);
  // Contents are not reset: the array models non-volatile cells.
  logic [7:0] mem_r [DEPTH];

  assign rd_data = mem_r[rd_addr];

  always_ff @(posedge clk) begin
    for (int i = 0; i < `SEP_PAGE_BYTES; i++) begin
      if (wr.en && wr.mask[i]) begin
        mem_r[{wr.page, `SEP_OFS_W'(i)}] <= wr.data[i];
      end
    end
  end
endmodule // sep_array

// [design/sep_top.sv]
// Two-wire serial memory slave with self-timed page programming.
`timescale 1ns/10ps
`include "sep_consts.svh"

// Function
// R1: Array of 2,048 bytes, sixteen-byte pages, one page per programming.
// R2: Partial pages program only the bytes actually received.
// R3: Programming is self-timed and ends within five milliseconds; here the count alone is five ms and the crossings add a few cycles.
// R4: During power-on reset all bus traffic is ignored, nothing acknowledged.
// R5: Reset release clears the control machine and enters standby.
// R6: Reset asserted again returns to standby, abandoning any transaction.
// R7: Stop enters standby unless programming runs; then after it ends.
// R8: Write-protect high blocks all programming; memory becomes read-only.
// R9: Write-protect low or floating allows normal programming; here a floating pin must be pulled low on the board.
// R10: Data line is only pulled low or released, never driven high.
// R11: Address strap inputs are ignored completely.
// R12: Transaction is selection byte, then address byte, then data bytes.
// R13: Master keeps the bus clock at or below 400 kHz or 1 MHz.
// R14: Serial clock is an input whose edges time every bit.
// R15: Respond only to selection nibble 1010; low bit one means read.
// R16: Three selection bits below the nibble choose a 256-byte block.
// R17: Page loading increments only the low four address bits, wrapping.
// R18: Selection is not acknowledged while programming; polling then works.
// R19: With protect high, bytes are acknowledged but programming skipped.
// R20: Clock and data inputs are synchronised and deglitched first.
module sep_top #(
  parameter int PROG_CYCLES = `SEP_T_WR_MS * `SEP_CLK_MHZ * 1000,
  parameter int FILT_LEN    = `SEP_FILT_LEN
) (
  input  wire logic clk,            // System clock, 200 MHz.
  input  wire logic sys_rst,        // Power-on reset, high.
  input  wire logic link_clk,       // Pin sampling clock.
  input  wire logic scl_i,          // Bus clock pin.
  input  wire logic sda_i,          // Data wire level.
  output logic      sda_o,          // Data drive level.
  output logic      sda_oe,         // Data pull-down enable.
  input  wire logic wp_i,           // Write protect pin.
  input  wire logic strap_bit_zero, // Address strap, unused.
  input  wire logic strap_bit_one,  // Address strap, unused.
  input  wire logic strap_bit_two,  // Address strap, unused.
  output logic      busy,           // Programming in progress.
  output logic      standby         // Idle and not programming.
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  function automatic logic bit_last(input logic [3:0] cnt);
    bit_last = (cnt == `SEP_BITS_PER_BYTE);
  endfunction

  sep_pkg::sep_state_t state_r;
  sep_pkg::sep_kind_t  kind_r;
  sep_pkg::sep_pins_t  pins_f;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shreg_r;
  logic        rw_r;
  logic        rst_m_r;
  logic        rst_l_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        byte_end;
  logic        tx_end;
  logic        dev_hit;
  logic        dev_take;
  logic        addr_take;
  logic        data_take;
  logic        launch;
  logic        wp_f;
  logic [`SEP_ADDR_W-1:0] addr_r;
  logic [`SEP_OFS_W-1:0]  ofs;
  logic [`SEP_PAGE_W-1:0] page;
  logic [`SEP_PAGE_BYTES-1:0][7:0] buf_r;
  logic [`SEP_PAGE_BYTES-1:0]      mask_r;
  logic        pend_r;
  logic        busy_r;
  logic        standby_r;
  logic        sda_o_r;
  logic [`SEP_PAGE_W-1:0] cpage_r;
  logic        req_t_r;
  logic        req_m_r;
  logic        req_s_r;
  logic        req_q_r;
  logic        req_ev;
  logic        run_r;
  logic [TW-1:0] prog_cnt_r;
  logic        done_t_r;
  logic        done_m_r;
  logic        done_s_r;
  logic        done_q_r;
  logic        done_ev;
  logic [7:0]  rd_data;
  sep_pkg::sep_page_wr_t page_wr;

  // The power-on reset reaches the link domain through two flops.
  always_ff @(posedge link_clk) begin
    rst_m_r <= sys_rst;
    rst_l_r <= rst_m_r;
  end

  // Filter length must stay well under a bus clock half period.
  sep_filt #(
    .W       (3),
    .LEN     (FILT_LEN),
    .RST_VAL (`SEP_PIN_IDLE)
  ) u_filt (
    .din  ({scl_i, sda_i, wp_i}),
    .clk  (link_clk),
    .rst  (rst_l_r),
    .dout (pins_f)
  ); // see R20 see R13

  // A floating protect pin must be pulled low on the board.
  assign wp_f = pins_f.wp; // see R9

  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= pins_f.scl;
      sda_q_r <= pins_f.sda;
    end
  end

  assign scl_rise = pins_f.scl & ~scl_q_r; // see R14
  assign scl_fall = ~pins_f.scl & scl_q_r; // see R14
  assign start_c  = pins_f.scl & scl_q_r & sda_q_r & ~pins_f.sda;
  assign stop_c   = pins_f.scl & scl_q_r & ~sda_q_r & pins_f.sda;
  assign byte_end = (state_r == sep_pkg::S_RX) && scl_fall &&
                    bit_last(bit_cnt_r);
  assign tx_end   = (state_r == sep_pkg::S_TX) && scl_fall &&
                    bit_last(bit_cnt_r);
  // The straps take no part in matching.
  assign dev_hit   = (shreg_r[7:4] == `SEP_DEV_CODE) && !busy_r; // see R11
  assign dev_take  = byte_end && (kind_r == sep_pkg::K_DEV) && dev_hit;
  assign addr_take = byte_end && (kind_r == sep_pkg::K_ADDR);
  assign data_take = byte_end && (kind_r == sep_pkg::K_DATA);
  assign ofs  = addr_r[`SEP_OFS_W-1:0];
  assign page = addr_r[`SEP_ADDR_W-1:`SEP_OFS_W];

  // Byte framing: select, address, then data.
  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      state_r   <= sep_pkg::S_IDLE; // see R4 see R5 see R6
      kind_r    <= sep_pkg::K_DEV;
      bit_cnt_r <= 4'h0;
      shreg_r   <= 8'h00;
      rw_r      <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start_c) begin
      state_r   <= sep_pkg::S_RX;
      kind_r    <= sep_pkg::K_DEV;
      bit_cnt_r <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (stop_c) begin
      state_r <= sep_pkg::S_IDLE; // see R7
      sda_oe  <= 1'b0;
    end else begin
      case (state_r)
        sep_pkg::S_RX: begin
          if (scl_rise) begin
            shreg_r   <= {shreg_r[6:0], pins_f.sda}; // see R14
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            if ((kind_r == sep_pkg::K_DEV) && !dev_hit) begin
              state_r <= sep_pkg::S_IDLE; // see R15 see R18
            end else begin
              state_r <= sep_pkg::S_ACK;
              sda_oe  <= 1'b1; // see R19
            end
            if (kind_r == sep_pkg::K_DEV) begin
              rw_r <= shreg_r[0]; // see R15
            end
          end
        end
        sep_pkg::S_ACK: begin
          if (scl_fall) begin
            if ((kind_r == sep_pkg::K_DEV) && rw_r) begin
              state_r   <= sep_pkg::S_TX;
              sda_oe    <= ~rd_data[7]; // see R10
              shreg_r   <= {rd_data[6:0], 1'b1};
              bit_cnt_r <= 4'h1;
            end else begin
              state_r   <= sep_pkg::S_RX; // see R12
              sda_oe    <= 1'b0;
              bit_cnt_r <= 4'h0;
              kind_r    <= (kind_r == sep_pkg::K_DEV) ? sep_pkg::K_ADDR
                                                      : sep_pkg::K_DATA;
            end
          end
        end
        sep_pkg::S_TX: begin
          if (tx_end) begin
            state_r <= sep_pkg::S_MACK;
            sda_oe  <= 1'b0;
          end else if (scl_fall) begin
            sda_oe    <= ~shreg_r[7]; // see R10
            shreg_r   <= {shreg_r[6:0], 1'b1};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        sep_pkg::S_MACK: begin
          // A master acknowledge reuses the acknowledge slot to load.
          if (scl_rise) begin
            if (pins_f.sda) begin
              state_r <= sep_pkg::S_IDLE;
            end else begin
              state_r <= sep_pkg::S_ACK;
              kind_r  <= sep_pkg::K_DEV;
            end
          end
        end
        sep_pkg::S_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_r <= sep_pkg::S_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Address pointer; reads roll over the whole array.
  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      addr_r <= '0;
    end else if (dev_take) begin
      addr_r[`SEP_ADDR_W-1:8] <= shreg_r[3:1]; // see R16
    end else if (addr_take) begin
      addr_r[7:0] <= shreg_r;
    end else if (data_take) begin
      addr_r[`SEP_OFS_W-1:0] <= ofs + 4'h1; // see R17
    end else if (tx_end) begin
      addr_r <= addr_r + 11'h001;
    end
  end

  // Page buffer; a mask records which bytes arrived.
  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      mask_r <= '0;
      pend_r <= 1'b0;
    end else begin
      if (addr_take) begin
        mask_r <= '0;
      end else if (data_take) begin
        buf_r[ofs]  <= shreg_r; // see R17
        mask_r[ofs] <= 1'b1;    // see R2
      end
      if (data_take) begin
        pend_r <= 1'b1;
      end else if (start_c || stop_c) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Protect is sampled at the stop; a blocked write leaves no trace.
  assign launch = stop_c && pend_r && !wp_f; // see R8 see R19

  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      busy_r  <= 1'b0;
      req_t_r <= 1'b0;
      cpage_r <= '0;
    end else if (launch) begin
      busy_r  <= 1'b1;
      req_t_r <= ~req_t_r;
      cpage_r <= page; // see R1
    end else if (done_ev) begin
      busy_r <= 1'b0; // see R7
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
      done_q_r <= 1'b0;
    end else begin
      done_m_r <= done_t_r;
      done_s_r <= done_m_r;
      done_q_r <= done_s_r;
    end
  end

  assign done_ev = done_s_r ^ done_q_r;

  always_ff @(posedge link_clk) begin
    if (rst_l_r) begin
      standby_r <= 1'b0;
      sda_o_r   <= 1'b0;
    end else begin
      standby_r <= (state_r == sep_pkg::S_IDLE) && !busy_r; // see R7
      sda_o_r   <= 1'b0; // see R10
    end
  end

  assign busy    = busy_r;
  assign standby = standby_r;
  assign sda_o   = sda_o_r;

  // Timer domain: the request toggle is synchronised before use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_q_r <= 1'b0;
    end else begin
      req_m_r <= req_t_r;
      req_s_r <= req_m_r;
      req_q_r <= req_s_r;
    end
  end

  assign req_ev = req_s_r ^ req_q_r;

  // The crossings add a few cycles on top of the programmed count.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r      <= 1'b0;
      prog_cnt_r <= '0;
      done_t_r   <= 1'b0;
    end else if (req_ev) begin
      run_r      <= 1'b1;
      prog_cnt_r <= TW'(PROG_CYCLES - 1); // see R3
    end else if (run_r) begin
      if (prog_cnt_r == '0) begin
        run_r    <= 1'b0;
        done_t_r <= ~done_t_r; // see R3
      end else begin
        prog_cnt_r <= prog_cnt_r - 1'b1;
      end
    end
  end

  always_comb begin
    page_wr.en   = done_ev && busy_r; // see R1
    page_wr.page = cpage_r;
    page_wr.mask = mask_r; // see R2
    page_wr.data = buf_r;
  end

  sep_array #(
    .DEPTH (`SEP_DEPTH),
    .AW    (`SEP_ADDR_W)
  ) u_array (
    .clk     (link_clk),
    .wr      (page_wr),
    .rd_addr (addr_r),
    .rd_data (rd_data)
  );

  sequence s_dev_end;
    byte_end && (kind_r == sep_pkg::K_DEV);
  endsequence

  sequence s_dev_acked;
    s_dev_end ##1 (state_r == sep_pkg::S_ACK);
  endsequence

  // Whenever the pin is enabled, its level must be low.
  property p_open_drain;
    @(posedge link_clk) disable iff (rst_l_r) sda_oe |-> sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) // see R10
    else $error("data line driven high");

  property p_por_quiet;
    @(posedge link_clk) rst_l_r |=> !sda_oe && !busy_r;
  endproperty
  a_por_quiet: assert property (p_por_quiet) // see R4
    else $error("bus answered during reset");

  property p_por_idle;
    @(posedge link_clk) $fell(rst_l_r) |-> state_r == sep_pkg::S_IDLE
      ##1 standby_r;
  endproperty
  a_por_idle: assert property (p_por_idle) // see R5
    else $error("no standby after reset release");

  property p_por_abort;
    @(posedge link_clk) $rose(rst_l_r) |=> !pend_r && !busy_r;
  endproperty
  a_por_abort: assert property (p_por_abort) // see R6
    else $error("transaction survived reset");

  property p_busy_nak;
    @(posedge link_clk) disable iff (rst_l_r)
      s_dev_end and busy_r |=> !sda_oe && state_r == sep_pkg::S_IDLE;
  endproperty
  a_busy_nak: assert property (p_busy_nak) // see R18
    else $error("selection acknowledged while busy");

  property p_dev_ack;
    @(posedge link_clk) disable iff (rst_l_r)
      s_dev_acked |-> sda_oe && shreg_r[7:4] == `SEP_DEV_CODE;
  endproperty
  a_dev_ack: assert property (p_dev_ack) // see R15
    else $error("wrong selection acknowledged");

  property p_blk_sel;
    @(posedge link_clk) disable iff (rst_l_r)
      dev_take |=> addr_r[`SEP_ADDR_W-1:8] == shreg_r[3:1];
  endproperty
  a_blk_sel: assert property (p_blk_sel) // see R16
    else $error("block bits not taken");

  property p_page_wrap;
    @(posedge link_clk) disable iff (rst_l_r)
      data_take |=> ofs == 4'($past(ofs) + 4'h1) && $stable(page);
  endproperty
  a_page_wrap: assert property (p_page_wrap) // see R17
    else $error("page offset did not wrap");

  property p_wp_block;
    @(posedge link_clk) disable iff (rst_l_r)
      $rose(busy_r) |-> !$past(wp_f);
  endproperty
  a_wp_block: assert property (p_wp_block) // see R8
    else $error("programming under write protect");

  property p_wp_ack;
    @(posedge link_clk) disable iff (rst_l_r)
      data_take && wp_f |=> sda_oe;
  endproperty
  a_wp_ack: assert property (p_wp_ack) // see R19
    else $error("protected byte not acknowledged");

  property p_stop_idle;
    @(posedge link_clk) disable iff (rst_l_r)
      stop_c && !pend_r && !busy_r |-> ##2 standby_r;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // see R7
    else $error("no standby after stop");

  property p_bit_edge;
    @(posedge link_clk) disable iff (rst_l_r)
      $changed(shreg_r) |-> $past(scl_rise) || $past(scl_fall) ||
                            $past(rst_l_r);
  endproperty
  a_bit_edge: assert property (p_bit_edge) // see R14
    else $error("bit moved without clock edge");

  property p_commit_mask;
    @(posedge link_clk) disable iff (rst_l_r)
      page_wr.en |-> page_wr.mask != '0;
  endproperty
  a_commit_mask: assert property (p_commit_mask) // see R2
    else $error("empty page committed");

  property p_prog_done;
    @(posedge clk) disable iff (sys_rst)
      run_r && prog_cnt_r == '0 |=> !run_r && $changed(done_t_r);
  endproperty
  a_prog_done: assert property (p_prog_done) // see R3
    else $error("programming timer did not finish");

  property p_prog_len;
    @(posedge clk) disable iff (sys_rst)
      run_r |-> prog_cnt_r < TW'(PROG_CYCLES);
  endproperty
  a_prog_len: assert property (p_prog_len) // see R3
    else $error("programming timer too long");
endmodule // sep_top

// [bench/sep_master_model.sv]
// Behavioural two-wire bus master that drives the bus clock and data pull.
`timescale 1ns/10ps
module sep_master_model (
  input  wire logic clk,      // Bench clock, paces the bus phases.
  output logic      scl,      // Bus clock, idles high.
  output logic      sda_pull, // High while the master pulls data low.
  input  wire logic sda       // Resolved data wire.
);
  // A bit is 70+70 low and 60 high cycles, exactly 1 MHz at 200 MHz.
  localparam int T_LO = 70;
  localparam int T_HI = 60;
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    wt(T_LO);
    sda_pull = 1'b0;
    wt(T_LO);
    scl = 1'b1;
    wt(T_HI);
    sda_pull = 1'b1;
    wt(T_HI);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(T_LO);
    sda_pull = 1'b1;
    wt(T_LO);
    scl = 1'b1;
    wt(T_HI);
    sda_pull = 1'b0;
    wt(T_HI);
  endtask
  // Data only changes in the middle of the low phase, never while high.
  task automatic bit_io(input logic b, output logic s);
    wt(T_LO);
    sda_pull = !b;
    wt(T_LO);
    scl = 1'b1;
    wt(T_HI / 2);
    s = sda;
    wt(T_HI / 2);
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, s);
  endtask
endmodule // sep_master_model

// [bench/test_serial_eeprom_2wire_slave.sv]
// Self-checking bench of the two-wire serial memory slave.
`timescale 1ns/10ps
module test_serial_eeprom_2wire_slave;
  localparam int PROG = 4000;
  logic       clk, link_clk, sys_rst, wp_i, bus_sda, m_scl, m_pull;
  logic       sda_o, sda_oe, busy, standby;
  logic [2:0] strap;
  int         failures, total_checks, busy_cnt;
  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    sys_rst = 1'b1;
    wp_i = 1'b0;
    strap = 3'h0;
    failures = 0;
    total_checks = 0;
    busy_cnt = 0;
  end
  always #2.5 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // The data wire has a pull-up; any party pulling wins.
  assign bus_sda = !(m_pull || (sda_oe && !sda_o));
  always @(negedge clk) if (busy === 1'b1) busy_cnt++;
  sep_top #(.PROG_CYCLES(PROG)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(m_scl),
    .sda_i(bus_sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i),
    .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]),
    .strap_bit_two(strap[2]), .busy(busy), .standby(standby));
  sep_master_model u_master (
    .clk(clk), .scl(m_scl), .sda_pull(m_pull), .sda(bus_sda));
  task automatic close_out();
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sel(input logic [7:0] b, input logic e, input string w);
    logic ack;
    u_master.start();
    u_master.wr_byte(b, ack);
    check(w, 8'(ack), 8'(e));
  endtask
  task automatic wr_seq(input logic [2:0] blk, input logic [7:0] a,
                        input int n, input logic [7:0] base,
                        input logic prot);
    logic ack;
    sel({4'ha, blk, 1'b0}, 1'b1, "select ack");
    u_master.wr_byte(a, ack);
    check("addr ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      u_master.wr_byte(base + 8'(i), ack);
      check("data ack", 8'(ack), 8'h01);
    end
    busy_cnt = 0;
    u_master.stop();
    if (prot) begin
      cyc(400);
      check("busy protected", 8'(busy), 8'h00);
      check("standby protected", 8'(standby), 8'h01);
    end else begin
      for (int i = 0; i < 400 && busy !== 1'b1; i++) cyc(1);
      check("busy start", 8'(busy), 8'h01);
      check("standby busy", 8'(standby), 8'h00);
      sel({4'ha, blk, 1'b0}, 1'b0, "poll nack");
      u_master.stop();
      for (int i = 0; i < PROG + 2000 && busy !== 1'b0; i++) cyc(1);
      check("busy span", 8'(busy_cnt >= PROG && busy_cnt <= PROG + 400),
            8'h01);
      cyc(20);
      check("standby after", 8'(standby), 8'h01);
    end
  endtask
  task automatic rd_seq(input logic [10:0] a, input int n,
                        input logic [2:0][7:0] e);
    logic       ack;
    logic [7:0] d;
    sel({4'ha, a[10:8], 1'b0}, 1'b1, "dummy select");
    u_master.wr_byte(a[7:0], ack);
    check("read addr ack", 8'(ack), 8'h01);
    sel({4'ha, a[10:8], 1'b1}, 1'b1, "read select");
    for (int i = 0; i < n; i++) begin
      u_master.rd_byte(i < n - 1, d);
      check("read data", d, e[i]);
    end
    u_master.stop();
  endtask
  // A short first reset, then traffic sent during a second, long one.
  task automatic t_reset();
    cyc(8);
    sys_rst = 1'b0;
    cyc(20);
    check("standby first", 8'(standby), 8'h01);
    sys_rst = 1'b1;
    cyc(48);
    sel(8'ha0, 1'b0, "ack in reset");
    u_master.stop();
    check("standby in reset", 8'(standby), 8'h00);
    sys_rst = 1'b0;
    cyc(120);
    check("standby up", 8'(standby), 8'h01);
    check("busy up", 8'(busy), 8'h00);
  endtask
  // A single byte, then a partial page that wraps past the page end.
  task automatic t_write();
    wr_seq(3'h3, 8'h22, 1, 8'h5a, 1'b0);
    strap = 3'h5;
    wr_seq(3'h3, 8'h2e, 4, 8'h10, 1'b0);
    rd_seq(11'h320, 3, {8'h5a, 8'h13, 8'h12});
  endtask
  task automatic t_protect();
    wp_i = 1'b1;
    wr_seq(3'h3, 8'h20, 1, 8'hee, 1'b1);
    wp_i = 1'b0;
  endtask
  task automatic t_refuse();
    strap = 3'h7;
    sel(8'hb0, 1'b0, "foreign select");
    u_master.stop();
  endtask
  // Reset lands after a data byte; the pending byte must be dropped.
  task automatic t_abort();
    logic ack;
    sel(8'ha6, 1'b1, "abort select");
    u_master.wr_byte(8'h21, ack);
    u_master.wr_byte(8'h77, ack);
    check("abort data ack", 8'(ack), 8'h01);
    sys_rst = 1'b1;
    cyc(48);
    check("oe in reset", 8'(sda_oe), 8'h00);
    check("standby reset", 8'(standby), 8'h00);
    sys_rst = 1'b0;
    u_master.stop();
    cyc(400);
    check("busy after abort", 8'(busy), 8'h00);
    check("standby again", 8'(standby), 8'h01);
    check("drive level", 8'(sda_o), 8'h00);
    rd_seq(11'h320, 2, {8'h00, 8'h13, 8'h12});
  endtask
  initial begin
    t_reset();
    t_write();
    t_protect();
    t_refuse();
    t_abort();
    close_out();
  end
  // The sequence needs about 65,000 cycles; the limit leaves a margin.
  initial begin
    cyc(90000);
    failures++;
    close_out();
  end
endmodule // test_serial_eeprom_2wire_slave
